// ===== design/mmvd_top.sv
`timescale 1ns/10ps
// Function
// - three 1M banks up to 2FFFFF; addresses above it and holes in the internal page are not routed
// - program ROM at 000000-00BFFF when internal boot
// - external boot releases program ROM range
// - RAM 00D800-00F7FF always internal
// - I/O page 00FF00-00FFFF never released
// - display pages 00F800-00FD7F offsets 00-7F internal
// - font ROM 010000-0EFFFF, released on external boot
// - vectors 000000-00004B, two bytes each
// - software vectors even, 00004E-0000FF
// - reset, zero divide, watchdog, keys 7..0
// - timer vector pairs, underflow first
// - serial error, receive, transmit at 28-2C
// - clock timer 32/8/2/1 Hz at 34-3A
// - reserved slots never assigned a factor
// - vector low byte first, then jump
// - highest priority pending factor served first
// - programmed level beats fixed order
// - push flags and PC except on reset
// - customized condition flag never driven
// - boot pin latched at reset release, held
// - no external strobes for internal accesses
module mmvd_top
    import mmvd_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic        BOOT_SOURCE_SELECT_PIN,
    input  wire logic [21:0] CPU_ADDR,
    input  wire logic        CPU_RD,
    input  wire logic        CPU_WR,
    input  wire logic [7:0]  CPU_WDATA,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic [32:0] FACTOR_REQ,
    input  wire logic [65:0] FACTOR_LEVEL,
    input  wire logic        SWI_REQ,
    input  wire logic [7:0]  SWI_VECTOR,
    input  wire logic        PUSH_DONE,
    input  wire logic        EXC_RETURN,
    output logic             SEL_PROG_ROM,
    output logic             SEL_FONT_ROM,
    output logic             SEL_RAM,
    output logic             SEL_DISPLAY,
    output logic             SEL_IO,
    output logic             ACC_RD,
    output logic             ACC_WR,
    output logic [21:0]      ACC_ADDR,
    output logic [7:0]       ACC_WDATA,
    output logic [2:0]       EXT_CE_N,
    output logic             EXT_RD_N,
    output logic             EXT_WR_N,
    output logic             EXT_DATA_OE_N,
    output logic             BOOT_INTERNAL,
    output logic             EXC_BUSY,
    output logic             PUSH_REQ,
    output logic             EXC_ACK,
    output logic [5:0]       EXC_INDEX,
    output logic [7:0]       EXC_VECTOR,
    output logic             JUMP_VALID,
    output logic [15:0]      JUMP_ADDR,
    output logic             SWI_REJECT,
    output logic             CUSTOM_COND_FLAG
);
    import mmvd_pkg::*;

    typedef enum logic [2:0] {
        ST_BOOT, ST_IDLE, ST_PUSH, ST_FETCH_LO, ST_WAIT_LO, ST_WAIT_HI
    } mmvd_state_type;

    mmvd_state_type  state_r;
    mmvd_state_type  state_nxt;
    mmvd_region_type region;
    logic            sync1_r;
    logic            sync2_r;
    logic            sync3_r;
    logic [1:0]      boot_cnt_r;
    logic            boot_done_r;
    logic            boot_int_r;
    logic [2:0]      active_lvl_r;
    logic [7:0]      vec_r;
    logic            is_reset_r;
    logic [7:0]      lo_byte_r;
    logic            pick_ok;
    logic [5:0]      pick_idx;
    logic [2:0]      best_lvl;
    logic [2:0]      eff;
    logic            take_hw;
    logic            take_swi;
    logic            swi_bad;
    logic            swi_legal;
    logic            fetching;
    logic            cpu_own;
    logic [21:0]     acc_addr;
    logic            acc_rd;
    logic            acc_wr;
    logic            is_ext;

    // boot pin: three stages, the first is read only by the second
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= BOOT_SOURCE_SELECT_PIN;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // the pin is caught once after release, when the pipe has filled;
    // it is ignored from then on until the next reset
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            boot_cnt_r  <= 2'd0;
            boot_done_r <= 1'b0;
            boot_int_r  <= 1'b1;
        end else if (!boot_done_r) begin
            if (boot_cnt_r != BOOT_SYNC) begin
                boot_cnt_r <= boot_cnt_r + 2'd1;
            end else if (sync2_r == sync3_r) begin
                boot_int_r  <= sync3_r;
                boot_done_r <= 1'b1;
            end
        end
    end

    // the two fault factors outrank any programmed level; among equal
    // levels the lower table index wins because of the >= on the way down
    always_comb begin
        pick_ok  = 1'b0;
        pick_idx = 6'd0;
        best_lvl = 3'd0;
        eff      = 3'd0;
        for (int i = NUM_FACT - 1; i >= 0; i--) begin
            eff = (i <= LAST_NMI) ? LVL_NMI : {1'b0, FACTOR_LEVEL[2*i +: 2]};
            if (FACTOR_REQ[i] && eff != 3'd0 && eff > active_lvl_r
                && eff >= best_lvl) begin
                best_lvl = eff;
                pick_ok  = 1'b1;
                pick_idx = 6'(i + 1);
            end
        end
    end

    assign swi_legal = !SWI_VECTOR[0] && (SWI_VECTOR >= SWI_VEC_LO);

    always_comb begin
        state_nxt = state_r;
        take_hw   = 1'b0;
        take_swi  = 1'b0;
        swi_bad   = 1'b0;
        case (state_r)
            ST_BOOT: begin
                if (boot_done_r) begin
                    state_nxt = ST_FETCH_LO;
                end
            end
            ST_IDLE: begin
                if (pick_ok) begin
                    take_hw   = 1'b1;
                    state_nxt = ST_PUSH;
                end else if (SWI_REQ && swi_legal) begin
                    take_swi  = 1'b1;
                    state_nxt = ST_PUSH;
                end else if (SWI_REQ) begin
                    swi_bad = 1'b1;
                end
            end
            ST_PUSH: begin
                if (PUSH_DONE) begin
                    state_nxt = ST_FETCH_LO;
                end
            end
            ST_FETCH_LO: state_nxt = ST_WAIT_LO;
            ST_WAIT_LO:  state_nxt = ST_WAIT_HI;
            ST_WAIT_HI:  state_nxt = ST_IDLE;
            default:     state_nxt = ST_BOOT;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_r  <= ST_BOOT;
            EXC_BUSY <= 1'b1;
            PUSH_REQ <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            EXC_BUSY <= (state_nxt != ST_IDLE);
            PUSH_REQ <= (state_nxt == ST_PUSH);
        end
    end

    // only one level is remembered: a return drops back to base level,
    // so nested services lose the outer level
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            active_lvl_r <= 3'd0;
        end else if (take_hw) begin
            active_lvl_r <= best_lvl;
        end else if (EXC_RETURN && state_r == ST_IDLE) begin
            active_lvl_r <= 3'd0;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            vec_r      <= VEC_RESET;
            is_reset_r <= 1'b1;
            EXC_ACK    <= 1'b0;
            EXC_INDEX  <= 6'd0;
            EXC_VECTOR <= VEC_RESET;
            SWI_REJECT <= 1'b0;
        end else begin
            EXC_ACK    <= take_hw;
            SWI_REJECT <= swi_bad;
            if (take_hw) begin
                vec_r      <= mmvd_vec_of(pick_idx);
                is_reset_r <= 1'b0;
                EXC_INDEX  <= pick_idx;
                EXC_VECTOR <= mmvd_vec_of(pick_idx);
            end else if (take_swi) begin
                vec_r      <= SWI_VECTOR;
                is_reset_r <= 1'b0;
            end
        end
    end

    // vector words are read through the normal decode, low byte first
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            lo_byte_r  <= 8'h00;
            JUMP_VALID <= 1'b0;
            JUMP_ADDR  <= 16'h0000;
        end else begin
            JUMP_VALID <= (state_r == ST_WAIT_HI);
            if (state_r == ST_WAIT_LO) begin
                lo_byte_r <= MEM_RDATA;
            end
            if (state_r == ST_WAIT_HI) begin
                JUMP_ADDR <= {MEM_RDATA, lo_byte_r};
            end
        end
    end

    assign fetching = (state_r == ST_FETCH_LO) || (state_r == ST_WAIT_LO);
    // the core keeps the bus while idle and while it pushes its context
    assign cpu_own  = (state_r == ST_IDLE) || (state_r == ST_PUSH);

    always_comb begin
        acc_addr = CPU_ADDR;
        acc_rd   = CPU_RD && cpu_own;
        acc_wr   = CPU_WR && cpu_own;
        if (fetching) begin
            acc_rd   = 1'b1;
            acc_wr   = 1'b0;
            acc_addr = {14'h0000, (state_r == ST_WAIT_LO) ? (vec_r | 8'h01) : vec_r};
        end
    end

    mmvd_decode u_dec (
        .addr          (acc_addr),
        .boot_internal (boot_int_r),
        .region        (region)
    );

    assign is_ext = (acc_rd || acc_wr) && (region == RG_EXT);

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            SEL_PROG_ROM  <= 1'b0;
            SEL_FONT_ROM  <= 1'b0;
            SEL_RAM       <= 1'b0;
            SEL_DISPLAY   <= 1'b0;
            SEL_IO        <= 1'b0;
            ACC_RD        <= 1'b0;
            ACC_WR        <= 1'b0;
            ACC_ADDR      <= 22'h000000;
            ACC_WDATA     <= 8'h00;
            EXT_CE_N      <= 3'b111;
            EXT_RD_N      <= 1'b1;
            EXT_WR_N      <= 1'b1;
            EXT_DATA_OE_N <= 1'b1;
        end else begin
            SEL_PROG_ROM  <= (acc_rd || acc_wr) && region == RG_PROG;
            SEL_FONT_ROM  <= (acc_rd || acc_wr) && region == RG_FONT;
            SEL_RAM       <= (acc_rd || acc_wr) && region == RG_RAM;
            SEL_DISPLAY   <= (acc_rd || acc_wr) && region == RG_DISP;
            SEL_IO        <= (acc_rd || acc_wr) && region == RG_IO;
            ACC_RD        <= acc_rd;
            ACC_WR        <= acc_wr;
            ACC_ADDR      <= acc_addr;
            ACC_WDATA     <= CPU_WDATA;
            // one chip enable per 1M bank
            EXT_CE_N      <= is_ext ? ~(3'b001 << acc_addr[21:20]) : 3'b111;
            EXT_RD_N      <= !(is_ext && acc_rd);
            EXT_WR_N      <= !(is_ext && acc_wr);
            EXT_DATA_OE_N <= !(is_ext && acc_wr);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            BOOT_INTERNAL    <= 1'b1;
            CUSTOM_COND_FLAG <= 1'b0;
        end else begin
            BOOT_INTERNAL    <= boot_int_r;
            CUSTOM_COND_FLAG <= 1'b0;
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    a_ram_stays_in: assert property (
        (acc_rd || acc_wr) && acc_addr >= RAM_LO && acc_addr <= RAM_HI
        |=> SEL_RAM && EXT_CE_N == 3'b111 && EXT_RD_N && EXT_WR_N)
        else $error("ram access leaked to external bus");

    a_io_stays_in: assert property (
        (acc_rd || acc_wr) && acc_addr >= IO_LO && acc_addr <= INT_HI
        |=> SEL_IO && EXT_CE_N == 3'b111)
        else $error("io access leaked to external bus");

    a_display_window: assert property (
        (acc_rd || acc_wr) && acc_addr >= 22'h00f800 && acc_addr <= 22'h00fd7f
        && acc_addr[7] == 1'b0 |=> SEL_DISPLAY && EXT_CE_N == 3'b111)
        else $error("display access not internal");

    a_prog_rom_boot: assert property (
        (acc_rd || acc_wr) && acc_addr <= PROG_HI
        |=> (BOOT_INTERNAL ? SEL_PROG_ROM : EXT_CE_N == 3'b110))
        else $error("program rom range routed wrongly");

    a_font_rom_boot: assert property (
        (acc_rd || acc_wr) && acc_addr >= FONT_LO && acc_addr <= FONT_HI
        |=> (BOOT_INTERNAL ? SEL_FONT_ROM : EXT_CE_N == 3'b110))
        else $error("font rom range routed wrongly");

    a_upper_bank_ext: assert property (
        acc_rd && acc_addr[21:20] == 2'b10 |=> EXT_CE_N == 3'b011 && !EXT_RD_N)
        else $error("third bank read missed its chip enable");

    a_quiet_internal: assert property (
        (SEL_PROG_ROM || SEL_FONT_ROM || SEL_RAM || SEL_DISPLAY || SEL_IO)
        |-> EXT_CE_N == 3'b111 && EXT_RD_N && EXT_WR_N && EXT_DATA_OE_N)
        else $error("external strobe during internal access");

    a_boot_held: assert property (
        boot_done_r && $past(boot_done_r) |-> $stable(boot_int_r))
        else $error("boot choice changed after latch");

    a_nmi_first: assert property (
        state_r == ST_IDLE && FACTOR_REQ[1] && !FACTOR_REQ[0] && active_lvl_r < LVL_NMI
        |=> EXC_ACK && EXC_INDEX == 6'd2 && EXC_VECTOR == 8'h04)
        else $error("watchdog not served first");

    a_key7_vector: assert property (
        EXC_ACK && EXC_INDEX == 6'd3 |-> EXC_VECTOR == 8'h06)
        else $error("key 7 vector wrong");

    a_ptm4_vector: assert property (
        EXC_ACK && EXC_INDEX == 6'd27 |-> EXC_VECTOR == 8'h3e)
        else $error("timer 4 compare vector wrong");

    a_serial_vector: assert property (
        EXC_ACK && EXC_INDEX == 6'd20 |-> EXC_VECTOR == 8'h2a)
        else $error("serial receive vector wrong");

    a_clock_vector: assert property (
        EXC_ACK && EXC_INDEX == 6'd25 |-> EXC_VECTOR == 8'h3a)
        else $error("clock 1 Hz vector wrong");

    a_no_reserved: assert property (
        EXC_ACK |-> !mmvd_vec_rsv(EXC_VECTOR) && EXC_VECTOR <= HW_VEC_HI)
        else $error("factor mapped to reserved slot");

    a_push_first: assert property (
        state_r == ST_FETCH_LO && !is_reset_r
        |-> $past(state_r) == ST_PUSH && $past(PUSH_DONE))
        else $error("vector fetched without context push");

    a_jump_bytes: assert property (
        JUMP_VALID |-> JUMP_ADDR == {$past(MEM_RDATA), $past(MEM_RDATA, 2)}
        && $past(ACC_ADDR[0]) && !$past(ACC_ADDR[0], 2))
        else $error("jump address bytes out of order");

    a_swi_reject: assert property (
        SWI_REJECT |-> $past(SWI_VECTOR[0]) || $past(SWI_VECTOR) < SWI_VEC_LO)
        else $error("legal software vector rejected");

    a_cc_quiet: assert property (
        !CUSTOM_COND_FLAG)
        else $error("customized condition flag driven");
endmodule // mmvd_top

// ===== design/mmvd_pkg.sv
package mmvd_pkg;
    localparam logic [21:0] BANK_TOP    = 22'h2fffff;
    localparam logic [21:0] PROG_HI     = 22'h00bfff;
    localparam logic [21:0] INT_LO      = 22'h00c000;
    localparam logic [21:0] INT_HI      = 22'h00ffff;
    localparam logic [21:0] RAM_LO      = 22'h00d800;
    localparam logic [21:0] RAM_HI      = 22'h00f7ff;
    localparam logic [21:0] IO_LO       = 22'h00ff00;
    localparam logic [21:0] FONT_LO     = 22'h010000;
    localparam logic [21:0] FONT_HI     = 22'h0effff;
    localparam logic [13:0] DISP_PG_LO  = 14'h00f8;
    localparam logic [13:0] DISP_PG_HI  = 14'h00fd;
    localparam logic [7:0]  DISP_OFS_HI = 8'h7f;
    localparam logic [7:0]  HW_VEC_HI   = 8'h4b;
    localparam logic [7:0]  SWI_VEC_LO  = 8'h4e;
    localparam logic [7:0]  RSV_A       = 8'h26;
    localparam logic [7:0]  RSV_B_LO    = 8'h2e;
    localparam logic [7:0]  RSV_B_HI    = 8'h32;
    localparam logic [7:0]  RSV_C       = 8'h4c;
    localparam logic [7:0]  VEC_RESET   = 8'h00;
    localparam logic [7:0]  VEC_SER     = 8'h28;
    localparam logic [7:0]  VEC_CLK     = 8'h34;
    localparam logic [7:0]  VEC_PTM_HI  = 8'h3c;
    localparam logic [5:0]  IDX_SER     = 6'd19;
    localparam logic [5:0]  IDX_CLK     = 6'd22;
    localparam logic [5:0]  IDX_PTM_HI  = 6'd26;
    localparam int          NUM_FACT    = 33;
    localparam int          LAST_NMI    = 1;
    localparam logic [2:0]  LVL_NMI     = 3'd4;
    localparam logic [1:0]  BOOT_SYNC   = 2'd3;

    typedef enum logic [2:0] {
        RG_NONE, RG_PROG, RG_FONT, RG_RAM, RG_DISP, RG_IO, RG_EXT
    } mmvd_region_type;

    function automatic logic [7:0] mmvd_vec_of(input logic [5:0] idx);
        logic [5:0] ofs;
        ofs = 6'd0;
        if (idx < IDX_SER) begin
            return {1'b0, idx, 1'b0};
        end else if (idx < IDX_CLK) begin
            ofs = idx - IDX_SER;
            return VEC_SER + {1'b0, ofs, 1'b0};
        end else if (idx < IDX_PTM_HI) begin
            ofs = idx - IDX_CLK;
            return VEC_CLK + {1'b0, ofs, 1'b0};
        end
        ofs = idx - IDX_PTM_HI;
        return VEC_PTM_HI + {1'b0, ofs, 1'b0};
    endfunction

    function automatic logic mmvd_vec_rsv(input logic [7:0] v);
        return (v == RSV_A) || ((v >= RSV_B_LO) && (v <= RSV_B_HI)) || (v == RSV_C);
    endfunction
endpackage

// ===== design/mmvd_decode.sv
`timescale 1ns/10ps
module mmvd_decode
    import mmvd_pkg::*;
(
    input  wire logic [21:0]     addr,
    input  wire logic            boot_internal,
    output mmvd_pkg::mmvd_region_type region
);
    // fixed internal windows are tested first so overlapping external
    // memory can never capture them
    always_comb begin
        if (addr > BANK_TOP) begin
            region = RG_NONE;
        end else if (addr >= IO_LO && addr <= INT_HI) begin
            region = RG_IO;
        end else if (addr[21:8] >= DISP_PG_LO && addr[21:8] <= DISP_PG_HI
                     && addr[7:0] <= DISP_OFS_HI) begin
            region = RG_DISP;
        end else if (addr >= RAM_LO && addr <= RAM_HI) begin
            region = RG_RAM;
        end else if (addr >= INT_LO && addr <= INT_HI) begin
            // holes in the internal page are never released either
            region = RG_NONE;
        end else if (addr <= PROG_HI) begin
            region = boot_internal ? RG_PROG : RG_EXT;
        end else if (addr >= FONT_LO && addr <= FONT_HI) begin
            region = boot_internal ? RG_FONT : RG_EXT;
        end else begin
            region = RG_EXT;
        end
    end
endmodule // mmvd_decode

// ===== tb/mmvd_core_mem.sv
`timescale 1ns/10ps
module mmvd_core_mem (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        acc_rd,
    input  wire logic [21:0] acc_addr,
    input  wire logic        push_req,
    output logic [7:0]       rdata,
    output logic             push_done
);
    logic [1:0] wait_r;
    logic [7:0] junk_r = 8'ha5;
    // an idle bus shows a moving pattern so a late capture cannot hit the right byte
    assign rdata = acc_rd ? (acc_addr[7:0] ^ acc_addr[15:8] ^ 8'h3c) : junk_r;
    always_ff @(posedge clk) begin
        junk_r <= junk_r + 8'h5b;
    end
    // the core takes a random 1 to 3 cycles to push flags and pc
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_done <= 1'b0;
            wait_r    <= 2'h0;
        end else if (push_done) begin
            push_done <= 1'b0;
        end else if (push_req) begin
            if (wait_r == 2'h0) begin
                push_done <= 1'b1;
                wait_r    <= 2'($urandom % 3);
            end else begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule // mmvd_core_mem

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import mmvd_pkg::*;
    logic        SYS_CLK, RESET, BOOT_SOURCE_SELECT_PIN, CPU_RD, CPU_WR, SWI_REQ, bi;
    logic        PUSH_DONE, EXC_RETURN, SEL_PROG_ROM, SEL_FONT_ROM, SEL_RAM, SEL_DISPLAY;
    logic        SEL_IO, ACC_RD, ACC_WR, EXT_RD_N, EXT_WR_N, EXT_DATA_OE_N, BOOT_INTERNAL;
    logic        EXC_BUSY, PUSH_REQ, EXC_ACK, JUMP_VALID, SWI_REJECT, CUSTOM_COND_FLAG;
    logic [21:0] CPU_ADDR, ACC_ADDR;
    logic [7:0]  CPU_WDATA, MEM_RDATA, ACC_WDATA, SWI_VECTOR, EXC_VECTOR;
    logic [32:0] FACTOR_REQ;
    logic [65:0] FACTOR_LEVEL;
    logic [2:0]  EXT_CE_N;
    logic [5:0]  EXC_INDEX;
    logic [15:0] JUMP_ADDR;
    logic [75:0] q[$], obs, ex;
    logic [34:0] idl = {13'h3f, 22'h0};
    logic [21:0] tbl [23] = '{22'h0, 22'h4b, 22'hbfff, 22'hc000, 22'hd7ff, 22'hd800,
        22'hf7ff, 22'hf800, 22'hf87f, 22'hf880, 22'hfd7f, 22'hfe00, 22'hfeff, 22'hff00,
        22'hffff, 22'h10000, 22'heffff, 22'hf0000, 22'h100000, 22'h1fffff, 22'h2fffff,
        22'h300000, 22'h3fffff};
    int          checks = 0, bad_count = 0;

    mmvd_top mmvd_top_inst (.SYS_CLK, .RESET, .BOOT_SOURCE_SELECT_PIN, .CPU_ADDR, .CPU_RD,
        .CPU_WR, .CPU_WDATA, .MEM_RDATA, .FACTOR_REQ, .FACTOR_LEVEL, .SWI_REQ, .SWI_VECTOR,
        .PUSH_DONE, .EXC_RETURN, .SEL_PROG_ROM, .SEL_FONT_ROM, .SEL_RAM, .SEL_DISPLAY,
        .SEL_IO, .ACC_RD, .ACC_WR, .ACC_ADDR, .ACC_WDATA, .EXT_CE_N, .EXT_RD_N, .EXT_WR_N,
        .EXT_DATA_OE_N, .BOOT_INTERNAL, .EXC_BUSY, .PUSH_REQ, .EXC_ACK, .EXC_INDEX,
        .EXC_VECTOR, .JUMP_VALID, .JUMP_ADDR, .SWI_REJECT, .CUSTOM_COND_FLAG);
    mmvd_core_mem mmvd_core_mem_inst (.clk(SYS_CLK), .rst(RESET), .acc_rd(ACC_RD),
        .acc_addr(ACC_ADDR), .push_req(PUSH_REQ), .rdata(MEM_RDATA), .push_done(PUSH_DONE));

    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    function automatic logic [75:0] mk(input logic [2:0] k, input logic [34:0] a,
        input logic [7:0] w, input logic [13:0] e, input logic [15:0] j);
        return {k, a, w, e, j};
    endfunction
    function automatic logic [7:0] dat(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [7:0] vexp(input int k);
        if (k <= 18) return 8'(2 * k);
        if (k <= 21) return 8'(8'h28 + 2 * (k - 19));
        if (k <= 25) return 8'(8'h34 + 2 * (k - 22));
        return 8'(8'h3c + 2 * (k - 26));
    endfunction

    task automatic chk(input logic [75:0] seen, input logic [75:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(negedge SYS_CLK) begin
        if (!RESET && (EXC_ACK || JUMP_VALID || SWI_REJECT || EXT_CE_N !== 3'b111
            || {SEL_PROG_ROM, SEL_FONT_ROM, SEL_RAM, SEL_DISPLAY, SEL_IO} !== 5'b0)) begin
            obs = mk({EXC_ACK, JUMP_VALID, SWI_REJECT}, {ACC_RD, ACC_WR, SEL_PROG_ROM,
                SEL_FONT_ROM, SEL_RAM, SEL_DISPLAY, SEL_IO, EXT_CE_N, EXT_RD_N, EXT_WR_N,
                EXT_DATA_OE_N, ACC_ADDR & {22{ACC_RD | ACC_WR}}}, ACC_WR ? ACC_WDATA : 8'h0,
                EXC_ACK ? {EXC_INDEX, EXC_VECTOR} : 14'h0, JUMP_VALID ? JUMP_ADDR : 16'h0);
            ex = (q.size() == 0) ? '1 : q.pop_front();
            chk(obs, ex);
        end
        chk(CUSTOM_COND_FLAG, 1'b0);
    end

    task automatic vseq(input logic [7:0] v);
        logic [21:0] a;
        a = {14'h0, v};
        // low byte first, then the byte above it
        for (int i = 0; i < 2; i++)
            q.push_back(mk(3'b0, {2'b10, bi, 6'h3, bi, bi, 2'h3, a[21:1], 1'(i)}, 0, 0, 0));
        q.push_back(mk(3'b010, idl, 0, 0, {dat({a[21:1], 1'b1}), dat(a)}));
    endtask
    task automatic wait_end;
        int i;
        for (i = 0; i < 40 && JUMP_VALID !== 1'b1 && SWI_REJECT !== 1'b1; i++)
            @(negedge SYS_CLK);
        chk(EXC_BUSY, 1'b0);
        @(negedge SYS_CLK);
        EXC_RETURN = 1'b1;
        @(negedge SYS_CLK);
        EXC_RETURN = 1'b0;
    endtask
    task automatic rst(input logic pin);
        int i;
        @(negedge SYS_CLK);
        RESET = 1'b1;
        BOOT_SOURCE_SELECT_PIN = pin;
        repeat (3) @(negedge SYS_CLK);
        chk({EXC_BUSY, EXT_CE_N, EXT_RD_N, EXT_WR_N, EXT_DATA_OE_N, BOOT_INTERNAL}, 8'hff);
        bi = pin;
        vseq(8'h00);
        RESET = 1'b0;
        for (i = 0; i < 40 && EXC_BUSY !== 1'b0; i++)
            @(negedge SYS_CLK);
        chk(BOOT_INTERNAL, pin);
    endtask
    task automatic acc(input logic [21:0] a, input logic wr);
        logic [4:0] s;
        logic       x;
        @(negedge SYS_CLK);
        s = {bi && a <= 22'hbfff, bi && a >= 22'h10000 && a <= 22'heffff,
            a >= 22'hd800 && a <= 22'hf7ff,
            a[21:12] == 10'hf && a[11:8] >= 4'h8 && a[11:8] <= 4'hd && !a[7], a >= 22'hff00
            && a <= 22'hffff};
        x = s == 5'b0 && a <= 22'h2fffff && !(a >= 22'hc000 && a <= 22'hffff);
        CPU_ADDR = a;
        CPU_RD = !wr;
        CPU_WR = wr;
        CPU_WDATA = 8'($urandom);
        if (s != 5'b0 || x)
            q.push_back(mk(3'b0, {!wr, wr, s, x ? ~(3'b1 << a[21:20]) : 3'b111, !(x && !wr),
                !(x && wr), !(x && wr), a}, wr ? CPU_WDATA : 8'h0, 14'h0, 16'h0));
    endtask
    task automatic decode_all;
        foreach (tbl[i])
            acc(tbl[i], 1'(i % 2));
        repeat (8)
            acc(22'($urandom % 22'h300000), 1'($urandom));
        @(negedge SYS_CLK);
        CPU_RD = 1'b0;
        CPU_WR = 1'b0;
    endtask
    task automatic exc(input logic [32:0] r, input logic [65:0] l, input int k);
        int i;
        q.push_back(mk(3'b100, idl, 0, {6'(k), vexp(k)}, 0));
        vseq(vexp(k));
        @(negedge SYS_CLK);
        FACTOR_REQ = r;
        FACTOR_LEVEL = l;
        for (i = 0; i < 20 && EXC_ACK !== 1'b1; i++)
            @(negedge SYS_CLK);
        chk(PUSH_REQ, 1'b1);
        FACTOR_REQ = 33'h0;
        wait_end();
    endtask
    task automatic swi(input logic [7:0] v, input logic ok);
        if (ok)
            vseq(v);
        else
            q.push_back(mk(3'b001, idl, 0, 0, 0));
        @(negedge SYS_CLK);
        SWI_REQ = 1'b1;
        SWI_VECTOR = v;
        @(negedge SYS_CLK);
        SWI_REQ = 1'b0;
        wait_end();
    endtask

    initial begin
        logic [65:0] lv;
        {RESET, BOOT_SOURCE_SELECT_PIN, bi, CPU_RD, CPU_WR, SWI_REQ, EXC_RETURN} = 7'h40;
        {CPU_ADDR, CPU_WDATA, SWI_VECTOR, FACTOR_REQ, FACTOR_LEVEL} = '0;
        void'($urandom(32'h7faedc49));
        rst(1'b1);
        decode_all();
        BOOT_SOURCE_SELECT_PIN = 1'b0;
        repeat (6) @(negedge SYS_CLK);
        decode_all();
        $display("internal boot map test done");
        rst(1'b0);
        decode_all();
        $display("external boot map test done");
        rst(1'b1);
        for (int k = 1; k <= 33; k++)
            exc(33'h1 << (k - 1), {33{2'b01}}, k);
        lv = {33{2'b01}};
        lv[61:60] = 2'b11;
        exc(33'h24, {33{2'b01}}, 3);
        exc(33'h40000004, lv, 31);
        exc(33'ha, {33{2'b11}}, 2);
        @(negedge SYS_CLK);
        FACTOR_REQ = 33'h400;
        FACTOR_LEVEL = '0;
        repeat (10) @(negedge SYS_CLK);
        FACTOR_REQ = 33'h0;
        $display("exception test done");
        swi(8'h4e, 1'b1);
        swi(8'hfe, 1'b1);
        repeat (3)
            swi(8'(8'h4e + 2 * ($urandom % 89)), 1'b1);
        swi(8'h4d, 1'b0);
        swi(8'h40, 1'b0);
        chk(q.size(), 0);
        $display("software interrupt test done");
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        bad_count++;
        end_sim();
    end
endmodule // tb_top
